// ===== rtl/uhi_regs.sv
// Holding registers, FIFOs and interrupt enable of one UART channel.
// Assumes line control, feature and FIFO control bits, the receiver,
// transmitter and modem logic all run on this clock; CTS is a raw pin.
//
// Notes on behaviour
// R1: Both holding registers sit at address 0, only while divisor access is clear.
// R2: A holding write captures the eight data bus bits as next transmit byte.
// R3: With FIFOs enabled a holding write pushes into the transmit FIFO.
// R4: Line status bit 5 shows the transmit side can accept; low means full.
// R5: Host must not write holding while line status bit 5 is low.
// R6: Holding read returns the received byte; line status bit 0 flags unread data.
// R7: Interrupt enable at address 1, read/write, resets to zero, divisor access clear.
// R8: FIFOs off and enable bit 0: interrupt while a received byte waits.
// R9: FIFOs on and enable bit 0: interrupt once receive fill reaches trigger.
// R10: FIFOs on and enable bit 1: interrupt while transmit fill below trigger.
// R11: FIFOs off and enable bit 1: interrupt while transmit holding is empty.
// R12: Enable bit 2: interrupt on any receive error condition.
// R13: Enable bit 3: interrupt on any modem status input change.
// R14: Enable bits 7:4 accessible only in enhanced mode; else left unchanged.
// R15: Enable bit 4 permits the sleep state.
// R16: No sleep while any interrupt condition is pending.
// R17: Sleep ends on holding write, receive start bit or modem change.
// R18: Enable bit 5: interrupt on reception of an Xoff character.
// R19: Enable bit 6: interrupt when RTS output rises.
// R20: Enable bit 7: interrupt when CTS input rises.
// R21: Interrupt output high while any enabled source is active.
`include "uhi_defines.svh"

module uhi_regs #(
   parameter int DEPTH = `UHI_FIFO_DEPTH
) (
   // Clock, reset and clock enable
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   // Host register bus
   input wire uhi_pkg::uhi_bus_req_t bus_req,
   output uhi_pkg::uhi_byte_t bus_rdata,
   // Mode bits from neighbouring registers
   input wire logic divisor_access,
   input wire logic enhanced_mode,
   input wire logic fifo_enable,
   input wire logic [1:0] tx_trigger_sel,
   input wire logic [1:0] rx_trigger_sel,
   // Line status flags
   output logic line_status_data_ready,
   output logic line_status_tx_ready,
   // Transmit byte stream to the serializer
   output logic tx_valid,
   output uhi_pkg::uhi_byte_t tx_data,
   input wire logic tx_ready,
   // Receive byte stream from the deserializer
   input wire logic rx_valid,
   input wire uhi_pkg::uhi_byte_t rx_data,
   output logic rx_ready,
   // Interrupt sources
   input wire logic rx_error_active,
   input wire logic modem_change,
   input wire logic xoff_received,
   input wire logic rx_start_bit,
   input wire logic rts_out,
   input wire logic cts_pin,
   input wire logic flow_irq_clear,
   // Interrupt and power
   output logic irq,
   output logic sleep
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   generate
      if (DEPTH < `UHI_RX_TRIG_3 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("uhi_regs: DEPTH must be a power of two of at least 64");
      end
   endgenerate

   uhi_pkg::uhi_byte_t ier_ff;
   uhi_pkg::uhi_byte_t tx_mem_ff [DEPTH];
   uhi_pkg::uhi_byte_t rx_mem_ff [DEPTH];
   logic [PW-1:0] tx_wptr_ff;
   logic [PW-1:0] tx_rptr_ff;
   logic [PW-1:0] rx_wptr_ff;
   logic [PW-1:0] rx_rptr_ff;
   logic [CW-1:0] tx_count_ff;
   logic [CW-1:0] rx_count_ff;
   logic [CW-1:0] capacity;
   logic [CW-1:0] tx_trigger;
   logic [CW-1:0] rx_trigger;
   logic holding_sel;
   logic ier_sel;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic txb_ready;
   logic rxb_valid;
   uhi_pkg::uhi_byte_t rxb_data;
   logic cts_meta_ff;
   logic cts_sync_ff;
   logic cts_prev_ff;
   logic rts_prev_ff;
   logic rts_pend_ff;
   logic cts_pend_ff;
   logic [7:0] active;
   logic pending;
   logic wake;

   // Address decode, gated by divisor access
   assign holding_sel = !divisor_access && bus_req.addr == `UHI_ADDR_HOLDING; // [R1]
   assign ier_sel = !divisor_access && bus_req.addr == `UHI_ADDR_INT_ENABLE; // [R7]

   // Single holding register unless FIFOs are on
   assign capacity = fifo_enable ? CW'(DEPTH) : CW'(`UHI_HOLD_CAPACITY); // [R3]

   always_comb begin
      unique case (tx_trigger_sel)
         2'h0: tx_trigger = CW'(`UHI_TX_TRIG_0);
         2'h1: tx_trigger = CW'(`UHI_TX_TRIG_1);
         2'h2: tx_trigger = CW'(`UHI_TX_TRIG_2);
         2'h3: tx_trigger = CW'(`UHI_TX_TRIG_3);
      endcase
      unique case (rx_trigger_sel)
         2'h0: rx_trigger = CW'(`UHI_RX_TRIG_0);
         2'h1: rx_trigger = CW'(`UHI_RX_TRIG_1);
         2'h2: rx_trigger = CW'(`UHI_RX_TRIG_2);
         2'h3: rx_trigger = CW'(`UHI_RX_TRIG_3);
      endcase
   end

   // Full holding drops the write
   assign tx_push = bus_req.wr && holding_sel && tx_count_ff < capacity; // [R2] [R5]
   assign tx_pop = tx_count_ff != '0 && txb_ready;
   assign rx_push = rxb_valid && rx_count_ff < capacity;
   assign rx_pop = bus_req.rd && holding_sel && rx_count_ff != '0; // [R6]

   // Storage, one entry per slot
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_entry
         always_ff @(posedge clock) begin
            if (reset) begin
               tx_mem_ff[i] <= 8'h00;
               rx_mem_ff[i] <= 8'h00;
            end else if (clk_en) begin
               if (tx_push && tx_wptr_ff == PW'(i)) begin
                  tx_mem_ff[i] <= bus_req.wdata; // [R2] [R3]
               end
               if (rx_push && rx_wptr_ff == PW'(i)) begin
                  rx_mem_ff[i] <= rxb_data;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         tx_wptr_ff <= '0;
         tx_rptr_ff <= '0;
         tx_count_ff <= '0;
      end else if (clk_en) begin
         if (tx_push) begin
            tx_wptr_ff <= tx_wptr_ff + PW'(1);
         end
         if (tx_pop) begin
            tx_rptr_ff <= tx_rptr_ff + PW'(1);
         end
         if (tx_push && !tx_pop) begin
            tx_count_ff <= tx_count_ff + CW'(1);
         end else if (tx_pop && !tx_push) begin
            tx_count_ff <= tx_count_ff - CW'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rx_wptr_ff <= '0;
         rx_rptr_ff <= '0;
         rx_count_ff <= '0;
      end else if (clk_en) begin
         if (rx_push) begin
            rx_wptr_ff <= rx_wptr_ff + PW'(1);
         end
         if (rx_pop) begin
            rx_rptr_ff <= rx_rptr_ff + PW'(1);
         end
         if (rx_push && !rx_pop) begin
            rx_count_ff <= rx_count_ff + CW'(1);
         end else if (rx_pop && !rx_push) begin
            rx_count_ff <= rx_count_ff - CW'(1);
         end
      end
   end

   uhi_skid #(
      .WIDTH(8)
   ) u_tx_buf (
      .clock(clock),
      .reset(reset),
      .clk_en(clk_en),
      .in_valid(tx_count_ff != '0),
      .in_data(tx_mem_ff[tx_rptr_ff]),
      .in_ready(txb_ready),
      .out_valid(tx_valid),
      .out_data(tx_data),
      .out_ready(tx_ready)
   );

   uhi_skid #(
      .WIDTH(8)
   ) u_rx_buf (
      .clock(clock),
      .reset(reset),
      .clk_en(clk_en),
      .in_valid(rx_valid),
      .in_data(rx_data),
      .in_ready(rx_ready),
      .out_valid(rxb_valid),
      .out_data(rxb_data),
      .out_ready(rx_count_ff < capacity)
   );

   // Interrupt enable register
   always_ff @(posedge clock) begin
      if (reset) begin
         ier_ff <= `UHI_INT_ENABLE_RESET; // [R7]
      end else if (clk_en && bus_req.wr && ier_sel) begin
         ier_ff[`UHI_IE_LOW_HI:0] <= bus_req.wdata[`UHI_IE_LOW_HI:0]; // [R7]
         if (enhanced_mode) begin
            ier_ff[7:`UHI_IE_HIGH_LO] <= bus_req.wdata[7:`UHI_IE_HIGH_LO]; // [R14]
         end
      end
   end

   // Read data; unmapped and blocked reads return zero
   always_ff @(posedge clock) begin
      if (reset) begin
         bus_rdata <= 8'h00;
      end else if (clk_en && bus_req.rd) begin
         if (holding_sel) begin
            bus_rdata <= rx_mem_ff[rx_rptr_ff]; // [R6]
         end else if (ier_sel) begin
            bus_rdata <= enhanced_mode ? ier_ff : {4'h0, ier_ff[`UHI_IE_LOW_HI:0]}; // [R14]
         end else begin
            bus_rdata <= 8'h00;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         line_status_data_ready <= 1'b0;
         line_status_tx_ready <= 1'b1;
      end else if (clk_en) begin
         line_status_data_ready <= rx_count_ff != '0; // [R6]
         line_status_tx_ready <= tx_count_ff < capacity; // [R4]
      end
   end

   // CTS pin synchroniser
   always_ff @(posedge clock) begin
      if (reset) begin
         cts_meta_ff <= 1'b0;
         cts_sync_ff <= 1'b0;
      end else if (clk_en) begin
         cts_meta_ff <= cts_pin;
         cts_sync_ff <= cts_meta_ff;
      end
   end

   // Sticky rising-edge flags; a new edge beats the clear
   always_ff @(posedge clock) begin
      if (reset) begin
         cts_prev_ff <= 1'b0;
         rts_prev_ff <= 1'b0;
         rts_pend_ff <= 1'b0;
         cts_pend_ff <= 1'b0;
      end else if (clk_en) begin
         cts_prev_ff <= cts_sync_ff;
         rts_prev_ff <= rts_out;
         if (rts_out && !rts_prev_ff) begin
            rts_pend_ff <= 1'b1; // [R19]
         end else if (flow_irq_clear) begin
            rts_pend_ff <= 1'b0;
         end
         if (cts_sync_ff && !cts_prev_ff) begin
            cts_pend_ff <= 1'b1; // [R20]
         end else if (flow_irq_clear) begin
            cts_pend_ff <= 1'b0;
         end
      end
   end

   // Source conditions
   always_comb begin
      active = 8'h00;
      active[`UHI_IE_RX_DATA] = fifo_enable ? rx_count_ff >= rx_trigger // [R9]
                                            : rx_count_ff != '0; // [R8]
      active[`UHI_IE_TX_EMPTY] = fifo_enable ? tx_count_ff < tx_trigger // [R10]
                                             : tx_count_ff == '0; // [R11]
      active[`UHI_IE_LINE_ERR] = rx_error_active; // [R12]
      active[`UHI_IE_MODEM] = modem_change; // [R13]
      active[`UHI_IE_XOFF] = xoff_received; // [R18]
      active[`UHI_IE_RTS] = rts_pend_ff; // [R19]
      active[`UHI_IE_CTS] = cts_pend_ff; // [R20]
   end

   assign pending = |(active & ier_ff);
   assign wake = tx_push || rx_start_bit || modem_change; // [R17]

   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= 1'b0;
         sleep <= 1'b0;
      end else if (clk_en) begin
         irq <= pending; // [R21]
         sleep <= ier_ff[`UHI_IE_SLEEP] && !pending && !wake; // [R15] [R16] [R17]
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset || !clk_en);

   sequence s_ier_write;
      bus_req.wr && ier_sel;
   endsequence

   sequence s_rts_rise;
      !rts_out ##1 rts_out;
   endsequence

   a_ier_reset_zero: assert property ($past(reset) |-> ier_ff == `UHI_INT_ENABLE_RESET) // [R7]
      else $error("enable register not zero after reset");

   a_ier_low_write: assert property (s_ier_write |=> // [R7]
      ier_ff[`UHI_IE_LOW_HI:0] == $past(bus_req.wdata[`UHI_IE_LOW_HI:0]))
      else $error("enable low bits not written");

   a_ier_high_locked: assert property (s_ier_write ##0 !enhanced_mode |=> // [R14]
      ier_ff[7:`UHI_IE_HIGH_LO] == $past(ier_ff[7:`UHI_IE_HIGH_LO]))
      else $error("enable high bits changed outside enhanced mode");

   a_divisor_blocks_ier: assert property (divisor_access |=> $stable(ier_ff)) // [R7]
      else $error("enable register written during divisor access");

   a_tx_push_count: assert property (tx_push && !tx_pop |=> // [R3]
      tx_count_ff == $past(tx_count_ff) + CW'(1))
      else $error("transmit write not stored");

   a_tx_ready_flag: assert property (tx_count_ff >= capacity ##1 1'b1 |-> // [R4]
      !line_status_tx_ready)
      else $error("line status shows space while full");

   a_irq_follow: assert property (##1 irq == $past(pending)) // [R21]
      else $error("interrupt does not follow enabled sources");

   a_sleep_pending: assert property (sleep |-> !$past(pending)) // [R16]
      else $error("slept with an interrupt pending");

   a_sleep_wake: assert property (wake |=> !sleep) // [R17]
      else $error("wake event did not end sleep");

   a_rts_irq: assert property (s_rts_rise ##0 ier_ff[`UHI_IE_RTS] ##1 // [R19]
      ier_ff[`UHI_IE_RTS] |-> ##1 irq)
      else $error("RTS rise raised no interrupt");

endmodule // uhi_regs

// ===== pkg/uhi_defines.svh
// Constants of the data holding and interrupt enable block.
// Included by the package and the register block; definitions only.
`ifndef UHI_DEFINES_SVH
`define UHI_DEFINES_SVH

// Register addresses on the 3-bit bus
`define UHI_ADDR_HOLDING 3'h0
`define UHI_ADDR_INT_ENABLE 3'h1

// Reset value of the interrupt enable register
`define UHI_INT_ENABLE_RESET 8'h00

// Interrupt enable bit positions
`define UHI_IE_RX_DATA 0
`define UHI_IE_TX_EMPTY 1
`define UHI_IE_LINE_ERR 2
`define UHI_IE_MODEM 3
`define UHI_IE_SLEEP 4
`define UHI_IE_XOFF 5
`define UHI_IE_RTS 6
`define UHI_IE_CTS 7

// Interrupt enable field split: bits 7:4 need enhanced mode
`define UHI_IE_LOW_HI 3
`define UHI_IE_HIGH_LO 4

// Transmit trigger levels per select code
`define UHI_TX_TRIG_0 8
`define UHI_TX_TRIG_1 16
`define UHI_TX_TRIG_2 32
`define UHI_TX_TRIG_3 56

// Receive trigger levels per select code
`define UHI_RX_TRIG_0 8
`define UHI_RX_TRIG_1 16
`define UHI_RX_TRIG_2 56
`define UHI_RX_TRIG_3 60

// Holding capacity while the FIFOs are disabled
`define UHI_HOLD_CAPACITY 1

// Documented FIFO depth
`define UHI_FIFO_DEPTH 64

`endif

// ===== pkg/uhi_pkg.sv
// Types shared by the data holding and interrupt enable block.
// Assumes uhi_defines.svh is on the include path.
`include "uhi_defines.svh"

package uhi_pkg;

   typedef logic [7:0] uhi_byte_t;

   // One host bus cycle: strobes are one-cycle pulses
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } uhi_bus_req_t;

endpackage

// ===== rtl/uhi_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; outputs come straight from flip-flops.
module uhi_skid #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic [WIDTH-1:0] d1_ff;
   logic push;
   logic pop;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("uhi_skid: WIDTH must be at least 1");
      end
   endgenerate

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_ff <= 2'h0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else if (clk_en) begin
         cnt_ff <= nxt_cnt;
         in_ready <= (nxt_cnt != 2'h2);
         out_valid <= (nxt_cnt != 2'h0);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         out_data <= '0;
         d1_ff <= '0;
      end else if (clk_en) begin
         if (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) begin
            out_data <= in_data;
         end else if (pop && cnt_ff == 2'h2) begin
            out_data <= d1_ff;
         end
         if (push && cnt_ff == 2'h1 && !pop) begin
            d1_ff <= in_data;
         end
      end
   end

endmodule // uhi_skid

// ===== testbench/uhi_serial_model.sv
// Behavioural serial engine on the far side of both byte streams.
// Assumes one clock; the bench calls send and reads the got queue.
module uhi_serial_model (
   // Clock, reset and stall control
   input wire logic clock,
   input wire logic reset,
   input wire logic stall,
   // Transmit stream
   input wire logic tx_valid,
   input wire uhi_pkg::uhi_byte_t tx_data,
   output logic tx_ready,
   // Receive stream
   output logic rx_valid,
   output uhi_pkg::uhi_byte_t rx_data,
   input wire logic rx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   uhi_pkg::uhi_byte_t got[$];
   assign tx_ready = !stall;
   always @(posedge clock) begin
      if (!reset && tx_valid && tx_ready) begin
         got.push_back(tx_data);
      end
   end
   initial begin
      rx_valid = 1'h0;
      rx_data = 8'hFF;
   end
   task automatic send(input uhi_pkg::uhi_byte_t b);
      @(posedge clock);
      rx_valid <= 1'h1;
      rx_data <= b;
      @(posedge clock);
      while (rx_ready !== 1'h1) @(posedge clock);
      rx_valid <= 1'h0;
      // Released data shows the inverse, never the old byte
      rx_data <= ~b;
   endtask
endmodule // uhi_serial_model

// ===== testbench/uhi_regs_tb.sv
// Self-checking bench of the holding and interrupt enable registers.
// Assumes the serial model stands on both byte streams.
module uhi_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic dl;
      logic enh;
      logic wr;
      logic [7:0] wd;
      logic [7:0] exp;
   } uhi_row_t;
   localparam uhi_row_t ROWS[6] = '{
      '{1'h0, 1'h0, 1'h1, 8'hFF, 8'h0F}, '{1'h0, 1'h1, 1'h1, 8'hA5, 8'hA5},
      '{1'h0, 1'h0, 1'h1, 8'h03, 8'h03}, '{1'h0, 1'h1, 1'h0, 8'h00, 8'hA3},
      '{1'h1, 1'h1, 1'h1, 8'h5A, 8'h00}, '{1'h0, 1'h1, 1'h0, 8'h00, 8'hA3}};
   localparam int RX_LVL[4] = '{8, 16, 56, 60};
   localparam int IE_BIT[5] = '{2, 3, 5, 6, 7};
   logic clock, reset, clk_en, stall, divisor_access, enhanced_mode, fifo_enable;
   logic [1:0] tx_trigger_sel, rx_trigger_sel;
   logic ldr, ltr, tx_valid, tx_ready, rx_valid, rx_ready;
   logic rx_start_bit, flow_irq_clear, irq, sleep;
   logic [4:0] src;
   uhi_pkg::uhi_bus_req_t bus_req;
   uhi_pkg::uhi_byte_t bus_rdata, tx_data, rx_data, v;
   int num_errors, comparisons, k;
   uhi_regs dut (.clock(clock), .reset(reset), .clk_en(clk_en), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .divisor_access(divisor_access), .enhanced_mode(enhanced_mode),
      .fifo_enable(fifo_enable), .tx_trigger_sel(tx_trigger_sel),
      .rx_trigger_sel(rx_trigger_sel), .line_status_data_ready(ldr),
      .line_status_tx_ready(ltr), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .rx_error_active(src[0]), .modem_change(src[1]), .xoff_received(src[2]),
      .rx_start_bit(rx_start_bit), .rts_out(src[3]), .cts_pin(src[4]),
      .flow_irq_clear(flow_irq_clear), .irq(irq), .sleep(sleep));
   uhi_serial_model model (.clock(clock), .reset(reset), .stall(stall),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
   task automatic conclude();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic wr(input logic [2:0] a, input uhi_pkg::uhi_byte_t d);
      @(posedge clock);
      bus_req <= '{1'h1, 1'h0, a, d};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [2:0] a, output uhi_pkg::uhi_byte_t d);
      @(posedge clock);
      bus_req <= '{1'h0, 1'h1, a, 8'h00};
      @(posedge clock);
      bus_req <= '0;
      @(negedge clock);
      d = bus_rdata;
   endtask
   // Writes while the transmit side has room, with the far side stalled
   task automatic fill(input int n);
      @(posedge clock);
      stall <= 1'h1;
      model.got.delete();
      k = 0;
      while (k < n && ltr === 1'h1) begin
         wr(3'h0, 8'h10 + 8'(k));
         settle(2);
         k++;
      end
   endtask
   task automatic drain_check();
      @(posedge clock);
      stall <= 1'h0;
      settle(40);
      chk8("tx count", 8'(k), 8'(model.got.size()));
      for (int i = 0; i < k && i < model.got.size(); i++) begin
         chk8("tx byte", 8'h10 + 8'(i), model.got[i]);
      end
   endtask
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      conclude();
   end
   initial begin
      {reset, stall, divisor_access, enhanced_mode, fifo_enable} = 5'h10;
      {tx_trigger_sel, rx_trigger_sel, src, rx_start_bit, flow_irq_clear} = '0;
      bus_req = '0;
      clk_en = 1'h1;
      num_errors = 0;
      comparisons = 0;
      repeat (10) @(posedge clock);
      reset <= 1'h0;
      @(negedge clock);
      chk1("data_ready", 1'h0, ldr);
      chk1("tx_ready", 1'h1, ltr);
      chk1("irq", 1'h0, irq);
      chk1("sleep", 1'h0, sleep);
      rd(3'h1, v);
      chk8("interrupt_enable", 8'h00, v);
      foreach (ROWS[i]) begin
         @(posedge clock);
         divisor_access <= ROWS[i].dl;
         enhanced_mode <= ROWS[i].enh;
         if (ROWS[i].wr) wr(3'h1, ROWS[i].wd);
         rd(3'h1, v);
         chk8("interrupt_enable", ROWS[i].exp, v);
      end
      // Single holding register, transmit empty interrupt
      wr(3'h1, 8'h02);
      fill(8);
      chk1("tx_ready", 1'h0, ltr);
      chk1("irq", 1'h0, irq);
      wr(3'h0, 8'hEE);
      drain_check();
      chk1("irq", 1'h1, irq);
      chk1("tx_ready", 1'h1, ltr);
      // FIFO transmit path, trigger level 8
      @(posedge clock);
      fifo_enable <= 1'h1;
      fill(12);
      chk8("tx accepted", 8'h0C, 8'(k));
      chk1("irq", 1'h0, irq);
      // Higher transmit triggers sit above the ten to twelve queued bytes
      for (int s = 1; s < 4; s++) begin
         @(posedge clock);
         tx_trigger_sel <= 2'(s);
         settle(2);
         chk1("irq tx trigger", 1'h1, irq);
      end
      @(posedge clock);
      tx_trigger_sel <= 2'h0;
      drain_check();
      chk1("irq", 1'h1, irq);
      // Receive without FIFO
      @(posedge clock);
      fifo_enable <= 1'h0;
      wr(3'h1, 8'h01);
      model.send(8'h3C);
      settle(4);
      chk1("data_ready", 1'h1, ldr);
      chk1("irq", 1'h1, irq);
      rd(3'h0, v);
      chk8("receive_holding", 8'h3C, v);
      settle(2);
      chk1("data_ready", 1'h0, ldr);
      chk1("irq", 1'h0, irq);
      // Receive FIFO at every trigger level
      for (int s = 0; s < 4; s++) begin
         @(posedge clock);
         fifo_enable <= 1'h1;
         rx_trigger_sel <= 2'(s);
         for (int i = 0; i < RX_LVL[s]; i++) begin
            if (i == RX_LVL[s] - 1) begin
               settle(4);
               chk1("irq below trigger", 1'h0, irq);
            end
            model.send(8'h40 + 8'(i));
         end
         settle(4);
         chk1("irq at trigger", 1'h1, irq);
         for (int i = 0; i < RX_LVL[s]; i++) begin
            rd(3'h0, v);
            chk8("receive_holding", 8'h40 + 8'(i), v);
         end
      end
      // Error, modem, Xoff, RTS and CTS sources, each enabled and masked
      for (int i = 0; i < 5; i++) begin
         for (int m = 1; m >= 0; m--) begin
            wr(3'h1, m ? 8'h01 << IE_BIT[i] : 8'h00);
            @(posedge clock);
            src[i] <= 1'h1;
            settle(6);
            chk1("irq source", m[0], irq);
            @(posedge clock);
            src[i] <= 1'h0;
            flow_irq_clear <= 1'h1;
            @(posedge clock);
            flow_irq_clear <= 1'h0;
            settle(6);
            chk1("irq cleared", 1'h0, irq);
         end
      end
      // Sleep entry, pending block and wake events
      wr(3'h1, 8'h10);
      settle(4);
      chk1("sleep", 1'h1, sleep);
      @(posedge clock);
      rx_start_bit <= 1'h1;
      @(posedge clock);
      rx_start_bit <= 1'h0;
      @(negedge clock);
      chk1("sleep start bit", 1'h0, sleep);
      settle(3);
      wr(3'h0, 8'h77);
      @(negedge clock);
      chk1("sleep holding write", 1'h0, sleep);
      settle(3);
      @(posedge clock);
      src[1] <= 1'h1;
      settle(2);
      chk1("sleep modem", 1'h0, sleep);
      @(posedge clock);
      src[1] <= 1'h0;
      wr(3'h1, 8'h14);
      @(posedge clock);
      src[0] <= 1'h1;
      settle(4);
      chk1("sleep pending", 1'h0, sleep);
      @(posedge clock);
      src[0] <= 1'h0;
      settle(4);
      chk1("sleep", 1'h1, sleep);
      // Frozen clock enable ignores a write
      @(posedge clock);
      clk_en <= 1'h0;
      wr(3'h1, 8'h00);
      @(posedge clock);
      clk_en <= 1'h1;
      rd(3'h1, v);
      chk8("interrupt_enable frozen", 8'h14, v);
      // Second reset in mid-run
      @(posedge clock);
      reset <= 1'h1;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      @(negedge clock);
      chk1("sleep after reset", 1'h0, sleep);
      chk1("irq after reset", 1'h0, irq);
      chk1("tx_ready after reset", 1'h1, ltr);
      rd(3'h1, v);
      chk8("interrupt_enable after reset", 8'h00, v);
      conclude();
   end
endmodule // uhi_regs_tb
